// ===== src/mqs_pkg.sv
package mqs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MQS_REG_CTRL     = 8'h00;
  localparam logic [7:0] MQS_REG_QSEL     = 8'h04;
  localparam logic [7:0] MQS_REG_AE_OFS   = 8'h08;
  localparam logic [7:0] MQS_REG_AF_OFS   = 8'h0C;
  localparam logic [7:0] MQS_REG_STATUS   = 8'h10;
  localparam logic [7:0] MQS_REG_ERB_WORD = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         MQS_CTRL_NQ_LSB    = 0;
  localparam int         MQS_CTRL_NQ_W      = 8;
  localparam int         MQS_CTRL_DFLT_BIT  = 8;
  localparam int         MQS_CTRL_DSEL_BIT  = 9;
  localparam logic [7:0] MQS_NQ_RESET       = 8'h80;
  localparam logic       MQS_DFLT_RESET     = 1'b1;
  localparam logic       MQS_DSEL_RESET     = 1'b0;
  localparam int         MQS_ST_MODE_BIT    = 0;
  localparam int         MQS_ST_AE_BIT      = 1;
  localparam int         MQS_ST_AF_BIT      = 2;
  localparam int         MQS_ST_OWN_BIT     = 3;
  localparam int         MQS_ST_CNT_LSB     = 16;

  // Preset offsets chosen by default programming
  localparam int         MQS_DFLT_OFS_LO    = 8;
  localparam int         MQS_DFLT_OFS_HI    = 128;

  // ----------------------------------------------------------------
  // Timing counts in clock cycles, and queues per status word
  // ----------------------------------------------------------------
  localparam int         MQS_FLAG_LAT       = 2;
  localparam int         MQS_WRITE_LAT      = 3;
  localparam int         MQS_SWITCH_LAT     = 3;
  localparam int         MQS_WORD_LAT       = 1;
  localparam int         MQS_QUEUES_PER_WORD = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } mqs_wb_req_t;

  typedef enum logic [1:0] {
    MQS_TOK_WAIT = 2'b01,
    MQS_TOK_OWN  = 2'b10
  } mqs_tok_t;

endpackage

// ===== src/mqs_status_flags.sv
`timescale 1ns/1ns
// Behaviour
// - Almost-empty flag shows only the read-selected queue; all queues tracked.
// - Default programming gives every queue offset 8 or 128.
// - Each queue keeps its own offset, 0 up to its depth.
// - Read queue switch shows on flag at third edge after selection.
// - Read reaching the boundary drives the flag low two cycles later.
// - Write leaving almost-empty raises the flag three cycles later.
// - Flag moves only on clock edges; writes update unselected queues too.
// - Mode input low at reset selects addressed status bus.
// - Strobe latches word address from low write address bits; shown next cycle.
// - Word k carries queues 8k..8k+7 on bus bits 0..7.
// - Bus bits beyond the configured queues are don't care.
// - Bus bit may lag one cycle on coincident access; active flag exact.
// - Eight queues or fewer: queues 0..7 shown constantly.
// - Mode input high at reset selects polled bus, one word per edge.
// - Sync output high only while the first status word is shown.
// - Master drives bus first; others keep outputs released.
// - After its last word a device passes the token onward.
// - Empty/ready bus is eight bits, eight queues per word.
module mqs_status_flags #(
  parameter int NQ      = 128,
  parameter int DEPTH   = 256,
  parameter int ID_BITS = 0
) (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST_B,
  // Register bus
  input  wire mqs_pkg::mqs_wb_req_t      WB_REQ,
  output logic                           WB_ACK,
  output logic [31:0]                    WB_DAT,
  // Read port
  input  wire logic [$clog2(NQ)-1:0]     READ_QUEUE_ADDRESS,
  input  wire logic                      READ_ADDRESS_ENABLE,
  input  wire logic                      READ_EN,
  output logic                           ALMOST_EMPTY_FLAG,
  output logic [7:0]                     EMPTY_READY_STATUS_BUS,
  // Write port
  input  wire logic [7:0]                WRITE_QUEUE_ADDRESS,
  input  wire logic                      WRITE_ADDRESS_ENABLE,
  input  wire logic                      WRITE_EN,
  input  wire logic                      FULL_STATUS_STROBE,
  output logic                           ALMOST_FULL_FLAG,
  // Almost-full status bus and expansion
  input  wire logic                      FLAG_BUS_MODE_SELECT,
  input  wire logic                      MASTER_SELECT,
  input  wire logic                      DEVICE_ID_BIT0,
  input  wire logic                      DEVICE_ID_BIT1,
  input  wire logic                      DEVICE_ID_BIT2,
  input  wire logic                      FULL_TOKEN_IN,
  output logic [7:0]                     ALMOST_FULL_STATUS_BUS,
  output logic                           ALMOST_FULL_STATUS_OE,
  output logic                           FULL_BUS_SYNC,
  output logic                           FULL_TOKEN_OUT
);
  import mqs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int QW = $clog2(NQ);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int WW = (NQ > 8) ? $clog2(NQ / MQS_QUEUES_PER_WORD) : 1;
  // Presets beyond the queue depth are held at the depth, not cut
  localparam int OFS_LO = (MQS_DFLT_OFS_LO > DEPTH) ? DEPTH : MQS_DFLT_OFS_LO;
  localparam int OFS_HI = (MQS_DFLT_OFS_HI > DEPTH) ? DEPTH : MQS_DFLT_OFS_HI;

  logic [CW-1:0] rcnt   [NQ];   // Reads at once, writes one cycle late
  logic [CW-1:0] wcnt   [NQ];   // Writes at once, reads one cycle late
  logic [CW-1:0] ae_ofs [NQ];
  logic [CW-1:0] af_ofs [NQ];

  logic [QW-1:0] rsel_p;
  logic [QW-1:0] rq;
  logic [QW-1:0] wsel_p;
  logic [QW-1:0] wq;
  logic          rd_ok;
  logic          wr_ok;
  logic          rd_d;
  logic          wr_d;
  logic [QW-1:0] rq_d;
  logic [QW-1:0] wq_d;
  logic          ae_r1;
  logic          af_r1;
  logic          poll_mode;
  logic [7:0]    nq_cfg;
  logic          dflt_prog;
  logic          dflt_sel;
  logic [QW-1:0] qsel;
  logic [WW-1:0] erb_word;
  logic [WW-1:0] word_sel;
  logic          addr_own;
  logic [WW-1:0] pidx;
  logic [WW-1:0] last_word;
  logic          small_cfg;
  logic          id_match;
  logic          boot;
  logic          own_now;
  mqs_tok_t      tok_state;
  logic          wb_hit;
  logic [31:0]   next_rdat;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Effective offset: preset or per-queue value
  function automatic logic [CW-1:0] eff_ofs(input logic [CW-1:0] v);
    if (dflt_prog) begin
      return dflt_sel ? CW'(OFS_HI) : CW'(OFS_LO);
    end
    return v;
  endfunction

  // Occupancy update from one increment and one decrement
  function automatic logic [CW-1:0] step(input logic [CW-1:0] c,
                                         input logic inc, input logic dec);
    if (inc && !dec) begin
      return c + CW'(1);
    end
    if (dec && !inc) begin
      return c - CW'(1);
    end
    return c;
  endfunction

  function automatic logic ae_of(input int q);
    return rcnt[q] <= eff_ofs(ae_ofs[q]);
  endfunction

  function automatic logic af_of(input int q);
    return wcnt[q] >= CW'(DEPTH) - eff_ofs(af_ofs[q]);
  endfunction

  // Active-low status word; bits past the last queue read high
  // unused bits high
  function automatic logic [7:0] af_word(input logic [WW-1:0] w);
    logic [7:0] r;
    int         q;
    r = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      q = int'(w) * MQS_QUEUES_PER_WORD + b;
      if (q < NQ) begin
        r[b] = !af_of(q);
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] ae_word(input logic [WW-1:0] w);
    logic [7:0] r;
    int         q;
    r = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      q = int'(w) * MQS_QUEUES_PER_WORD + b;
      if (q < NQ) begin
        r[b] = !ae_of(q);
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Configuration derived values
  // ----------------------------------------------------------------
  // Index of the last word for the configured queue count
  assign last_word = WW'((({1'b0, nq_cfg} + 9'h007) >> 3) - 9'h001);
  assign small_cfg = (nq_cfg <= 8'h08);
  assign id_match  = (ID_BITS == 0) ||
    (WRITE_QUEUE_ADDRESS[7 -: 3] >> (3 - ID_BITS)) ==
    ({DEVICE_ID_BIT2, DEVICE_ID_BIT1, DEVICE_ID_BIT0} >> (3 - ID_BITS));

  // Bus mode is caught while reset is held
  // mode strap capture
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      poll_mode <= FLAG_BUS_MODE_SELECT;
    end
  end

  // ----------------------------------------------------------------
  // Queue selection and occupancy
  // ----------------------------------------------------------------
  assign rd_ok = READ_EN && (rcnt[rq] != '0);
  assign wr_ok = WRITE_EN && (wcnt[wq] < CW'(DEPTH));

  // Two-stage queue selection on both ports
  // switch pipeline
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rsel_p <= '0;
      rq     <= '0;
      wsel_p <= '0;
      wq     <= '0;
    end else begin
      if (READ_ADDRESS_ENABLE) begin
        rsel_p <= READ_QUEUE_ADDRESS;
      end
      if (WRITE_ADDRESS_ENABLE) begin
        wsel_p <= WRITE_QUEUE_ADDRESS[QW-1:0];
      end
      rq <= rsel_p;
      wq <= wsel_p;
    end
  end

  // Delayed copies of the operations for the opposite view
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rd_d <= 1'b0;
      wr_d <= 1'b0;
      rq_d <= '0;
      wq_d <= '0;
    end else begin
      rd_d <= rd_ok;
      wr_d <= wr_ok;
      rq_d <= rq;
      wq_d <= wq;
    end
  end

  // Every queue tracked, selected or not
  // writes update unselected queues too
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < NQ; i++) begin
        rcnt[i] <= '0;
        wcnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NQ; i++) begin
        rcnt[i] <= step(rcnt[i], wr_d && wq_d == QW'(i), rd_ok && rq == QW'(i));
        wcnt[i] <= step(wcnt[i], wr_ok && wq == QW'(i), rd_d && rq_d == QW'(i));
      end
    end
  end

  // ----------------------------------------------------------------
  // Active flags, double registered
  // ----------------------------------------------------------------
  // selected queue only
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ae_r1             <= 1'b0;
      ALMOST_EMPTY_FLAG <= 1'b0;
      af_r1             <= 1'b1;
      ALMOST_FULL_FLAG  <= 1'b1;
    end else begin
      ae_r1             <= !ae_of(int'(rq));
      ALMOST_EMPTY_FLAG <= ae_r1;
      af_r1             <= !af_of(int'(wq));
      ALMOST_FULL_FLAG  <= af_r1;
    end
  end

  // Empty/ready word chosen by software
  // eight-queue word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      EMPTY_READY_STATUS_BUS <= 8'hFF;
    end else begin
      EMPTY_READY_STATUS_BUS <= ae_word(erb_word);
    end
  end

  // ----------------------------------------------------------------
  // Almost-full status bus
  // ----------------------------------------------------------------
  assign own_now = (tok_state == MQS_TOK_OWN) ||
                   (FULL_TOKEN_IN || (boot && MASTER_SELECT));

  // Word address latch and bus ownership in addressed mode
  // strobe latches word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      word_sel <= '0;
      addr_own <= 1'b0;
    end else if (FULL_STATUS_STROBE) begin
      word_sel <= WRITE_QUEUE_ADDRESS[WW-1:0];
      addr_own <= id_match;
    end
  end

  // Token ring state
  // pass after last word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tok_state      <= MQS_TOK_WAIT;
      pidx           <= '0;
      boot           <= 1'b1;
      FULL_TOKEN_OUT <= 1'b0;
    end else begin
      boot           <= 1'b0;
      FULL_TOKEN_OUT <= 1'b0;
      if (poll_mode && own_now) begin
        if (pidx >= last_word) begin
          pidx           <= '0;
          tok_state      <= MQS_TOK_WAIT;
          FULL_TOKEN_OUT <= 1'b1;
        end else begin
          pidx      <= pidx + WW'(1);
          tok_state <= MQS_TOK_OWN;
        end
      end
    end
  end

  // Bus data, enable and sync
  // word to bit mapping
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ALMOST_FULL_STATUS_BUS <= 8'hFF;
      ALMOST_FULL_STATUS_OE  <= 1'b0;
      FULL_BUS_SYNC          <= 1'b0;
    end else if (poll_mode) begin
      ALMOST_FULL_STATUS_BUS <= af_word(own_now ? pidx : '0);
      ALMOST_FULL_STATUS_OE  <= own_now;
      FULL_BUS_SYNC          <= own_now && (pidx == '0);
    end else begin
      ALMOST_FULL_STATUS_BUS <= af_word(small_cfg ? '0 : word_sel);
      ALMOST_FULL_STATUS_OE  <= small_cfg || addr_own;
      FULL_BUS_SYNC          <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign wb_hit = WB_REQ.cyc && WB_REQ.stb;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      WB_ACK <= 1'b0;
    end else begin
      WB_ACK <= wb_hit && !WB_ACK;
    end
  end

  // Read data mux; unmapped reads as zero
  always_comb begin
    next_rdat = 32'h0000_0000;
    unique case (WB_REQ.adr)
      MQS_REG_CTRL: begin
        next_rdat[MQS_CTRL_NQ_LSB +: MQS_CTRL_NQ_W] = nq_cfg;
        next_rdat[MQS_CTRL_DFLT_BIT] = dflt_prog;
        next_rdat[MQS_CTRL_DSEL_BIT] = dflt_sel;
      end
      MQS_REG_QSEL:     next_rdat[QW-1:0] = qsel;
      MQS_REG_AE_OFS:   next_rdat[CW-1:0] = ae_ofs[qsel];
      MQS_REG_AF_OFS:   next_rdat[CW-1:0] = af_ofs[qsel];
      MQS_REG_STATUS: begin
        next_rdat[MQS_ST_MODE_BIT] = poll_mode;
        next_rdat[MQS_ST_AE_BIT]   = ALMOST_EMPTY_FLAG;
        next_rdat[MQS_ST_AF_BIT]   = ALMOST_FULL_FLAG;
        next_rdat[MQS_ST_OWN_BIT]  = tok_state == MQS_TOK_OWN;
        next_rdat[MQS_ST_CNT_LSB +: CW] = rcnt[qsel];
      end
      MQS_REG_ERB_WORD: next_rdat[WW-1:0] = erb_word;
      default:          next_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      WB_DAT <= 32'h0000_0000;
    end else if (wb_hit && !WB_ACK) begin
      WB_DAT <= next_rdat;
    end
  end

  // Register writes take effect on the acked edge
  // preset offset select
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      nq_cfg    <= MQS_NQ_RESET;
      dflt_prog <= MQS_DFLT_RESET;
      dflt_sel  <= MQS_DSEL_RESET;
      qsel      <= '0;
      erb_word  <= '0;
      for (int i = 0; i < NQ; i++) begin
        ae_ofs[i] <= CW'(OFS_LO);
        af_ofs[i] <= CW'(OFS_LO);
      end
    end else if (wb_hit && WB_ACK && WB_REQ.we && WB_REQ.sel[0]) begin
      unique case (WB_REQ.adr)
        MQS_REG_CTRL: begin
          nq_cfg    <= (WB_REQ.dat[7:0] == 8'h00) ? 8'h01 : WB_REQ.dat[7:0];
          dflt_prog <= WB_REQ.dat[MQS_CTRL_DFLT_BIT];
          dflt_sel  <= WB_REQ.dat[MQS_CTRL_DSEL_BIT];
        end
        MQS_REG_QSEL:     qsel         <= WB_REQ.dat[QW-1:0];
        MQS_REG_AE_OFS:   ae_ofs[qsel] <= WB_REQ.dat[CW-1:0];
        MQS_REG_AF_OFS:   af_ofs[qsel] <= WB_REQ.dat[CW-1:0];
        MQS_REG_ERB_WORD: erb_word     <= WB_REQ.dat[WW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  logic          ae_sel;
  logic          af_sel;
  logic [CW-1:0] ae_off_sel;
  logic [7:0]    af_word_cur;
  assign ae_sel      = ae_of(int'(rq));
  assign af_sel      = af_of(int'(wq));
  assign ae_off_sel  = eff_ofs(ae_ofs[rq]);
  assign af_word_cur = af_word(small_cfg ? '0 : word_sel);

  ae_pipe_a: assert property (ALMOST_EMPTY_FLAG == !$past(ae_sel, 2))
    else $error("almost-empty flag not two stages behind selected queue");
  af_pipe_a: assert property (ALMOST_FULL_FLAG == !$past(af_sel, 2))
    else $error("active almost-full flag out of step");
  rd_switch_a: assert property (READ_ADDRESS_ENABLE ##1 !READ_ADDRESS_ENABLE
    |-> ##1 rq == $past(READ_QUEUE_ADDRESS, 2))
    else $error("read queue switch not taken in time");
  ae_write_a: assert property ((wr_ok && wq == rq && !rd_ok && !wr_d &&
    rcnt[rq] == ae_off_sel) ##1 (!rd_ok && $stable(rq))[*2]
    |-> ##1 !ALMOST_EMPTY_FLAG ##1 ALMOST_EMPTY_FLAG)
    else $error("almost-empty flag did not rise three cycles after write");
  word_latch_a: assert property (FULL_STATUS_STROBE
    |=> word_sel == $past(WRITE_QUEUE_ADDRESS[WW-1:0]))
    else $error("status word address not latched");
  addr_bus_a: assert property (!poll_mode |=> ALMOST_FULL_STATUS_BUS == $past(af_word_cur))
    else $error("addressed bus word wrong");
  small_cfg_a: assert property (!poll_mode && small_cfg |=> ALMOST_FULL_STATUS_OE)
    else $error("small configuration not driven");
  sync_first_a: assert property (FULL_BUS_SYNC
    |-> poll_mode && ALMOST_FULL_STATUS_OE && $past(pidx) == '0)
    else $error("sync high on a later word");
  tok_pass_a: assert property (poll_mode && own_now && pidx >= last_word
    |=> FULL_TOKEN_OUT && tok_state == MQS_TOK_WAIT)
    else $error("token not passed after last word");
  master_first_a: assert property (boot && MASTER_SELECT && poll_mode
    |=> ALMOST_FULL_STATUS_OE && FULL_BUS_SYNC)
    else $error("master did not start the bus");
  release_a: assert property (poll_mode && !own_now |=> !ALMOST_FULL_STATUS_OE)
    else $error("bus driven without token");
  mode_hold_a: assert property ($stable(poll_mode))
    else $error("bus mode changed outside reset");
  dflt_ofs_a: assert property (dflt_prog
    |-> ae_off_sel == (dflt_sel ? CW'(OFS_HI) : CW'(OFS_LO)))
    else $error("preset offset not applied");

  tok_ring_c: cover property (poll_mode && FULL_TOKEN_OUT ##[1:20] FULL_BUS_SYNC);
  ae_fall_c:  cover property (ALMOST_EMPTY_FLAG ##1 !ALMOST_EMPTY_FLAG);
  rd_sw_c:    cover property (READ_ADDRESS_ENABLE ##3 $changed(ALMOST_EMPTY_FLAG));
  word_sel_c: cover property (!poll_mode && FULL_STATUS_STROBE && id_match);

endmodule

// ===== tb/mqs_ctrl_model.sv
`timescale 1ns/1ns
module mqs_ctrl_model (
  // Token ring
  input  wire logic tok_out,
  output logic      tok_in
);
  // ------------------------------------------------------------
  // Board token path
  // ------------------------------------------------------------
  // token looped back
  assign tok_in = tok_out; // Single device feeds itself the token
endmodule

// ===== tb/tb_multiqueue_status_flag_logic.sv
`timescale 1ns/1ns
module tb_multiqueue_status_flag_logic;
  import mqs_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk, rst_b, raen, ren, waen, wen, full_status_strobe, fm;
  logic        ack, aef, aff, oe, sync, tok_in, tok_out, master_select;
  logic [2:0]  did;
  logic [6:0]  rqa;
  logic [7:0]  wqa, erb, afbus;
  logic [31:0] rdat, q;
  mqs_wb_req_t req;
  int          err_count, num_checks;

  // Design with a shallow queue so almost-full is reachable
  mqs_status_flags #(.NQ(128), .DEPTH(16)) dut_u (
    .CLK(clk), .RST_B(rst_b), .WB_REQ(req), .WB_ACK(ack), .WB_DAT(rdat),
    .READ_QUEUE_ADDRESS(rqa), .READ_ADDRESS_ENABLE(raen), .READ_EN(ren),
    .ALMOST_EMPTY_FLAG(aef), .EMPTY_READY_STATUS_BUS(erb),
    .WRITE_QUEUE_ADDRESS(wqa), .WRITE_ADDRESS_ENABLE(waen), .WRITE_EN(wen),
    .FULL_STATUS_STROBE(full_status_strobe), .ALMOST_FULL_FLAG(aff), .FLAG_BUS_MODE_SELECT(fm),
    .MASTER_SELECT(master_select), .DEVICE_ID_BIT0(did[0]), .DEVICE_ID_BIT1(did[1]),
    .DEVICE_ID_BIT2(did[2]), .FULL_TOKEN_IN(tok_in), .ALMOST_FULL_STATUS_BUS(afbus),
    .ALMOST_FULL_STATUS_OE(oe), .FULL_BUS_SYNC(sync), .FULL_TOKEN_OUT(tok_out));

  // Far-side controller model
  mqs_ctrl_model ctrl_u (.tok_out(tok_out), .tok_in(tok_in));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic at(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic hang();
    err_count++;
    $display("[ERR] wait expected done seen timeout");
    final_report();
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) hang();
    q = rdat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic do_reset(input logic mode);
    @(posedge clk);
    rst_b <= 1'b0;
    fm    <= mode;
    at(6);
    rst_b <= 1'b1;
  endtask

  task automatic rd_sel(input logic [6:0] qn);
    @(posedge clk);
    raen <= 1'b1;
    rqa  <= qn;
    @(posedge clk);
    raen <= 1'b0;
  endtask

  // Select write queue, then n writes; returns at the last write edge
  task automatic wr_q(input logic [7:0] qn, input int n);
    @(posedge clk);
    waen <= 1'b1;
    wqa  <= qn;
    @(posedge clk);
    waen <= 1'b0;
    at(2);
    wen  <= 1'b1;
    at(n);
    wen  <= 1'b0;
  endtask

  task automatic wait_aef(input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (aef !== v && n < 100);
    if (n >= 100) hang();
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_regs();
    wb(1'b0, MQS_REG_CTRL, 32'h0);
    chk("ctrl", q, {22'h0, MQS_DSEL_RESET, MQS_DFLT_RESET, MQS_NQ_RESET});
    wb(1'b0, MQS_REG_STATUS, 32'h0);
    chk("status", q, 32'h00000004);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h00000000);
  endtask

  task automatic sc_empty_flag();
    rd_sel(7'h00);
    wr_q(8'h00, 8);
    at(2); #1 chk("aff q0", aff, 1'b0);
    wr_q(8'h00, 1);
    at(2); #1 chk("aef w+2", aef, 1'b0);
    at(1); #1 chk("aef w+3", aef, 1'b1);
    rd_sel(7'h01);
    at(2); #1 chk("aef e+2", aef, 1'b1);
    at(1); #1 chk("aef e+3", aef, 1'b0);
    rd_sel(7'h00);
    at(3); #1 chk("aef back", aef, 1'b1);
    @(posedge clk);
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    at(1); #1 chk("aef r+1", aef, 1'b1);
    at(1); #1 chk("aef r+2", aef, 1'b0);
    wr_q(8'h01, 9);
    rd_sel(7'h01);
    at(3); #1 chk("aef other", aef, 1'b1);
    chk("erb word0", erb, 8'h02);
  endtask

  // Queues 0,1 and 9 almost full; back-to-back word strobes
  // no write select with strobe
  // identity bits left zero for one device
  task automatic sc_words();
    wr_q(8'h09, 8);
    @(posedge clk);
    full_status_strobe <= 1'b1;
    wqa  <= 8'h21;
    @(posedge clk);
    wqa  <= 8'h20;
    @(posedge clk);
    wqa  <= 8'h23;
    #1 chk("word1", afbus, 8'hFD);
    @(posedge clk);
    full_status_strobe <= 1'b0;
    #1 chk("word0", afbus, 8'hFC);
    @(posedge clk);
    #1 chk("word3", afbus, 8'hFF);
    chk("oe", oe, 1'b1);
  endtask

  task automatic sc_offsets();
    wb(1'b1, MQS_REG_CTRL, 32'h00000380);
    wait_aef(1'b0);
    chk("aef preset", aef, 1'b0);
    rd_sel(7'h00);
    wb(1'b1, MQS_REG_QSEL, 32'h0);
    wb(1'b1, MQS_REG_AE_OFS, 32'h00000005);
    wb(1'b1, MQS_REG_CTRL, 32'h00000080);
    wait_aef(1'b1);
    chk("aef own ofs", aef, 1'b1);
    wb(1'b1, MQS_REG_ERB_WORD, 32'h00000001);
    at(1); #1 chk("erb word1", erb, 8'h00);
    wb(1'b1, MQS_REG_CTRL, 32'h00000004);
    at(1); #1 chk("small word", afbus, 8'hFC);
  endtask

  // single device runs the bus polled
  task automatic sc_polled();
    do_reset(1'b1);
    wb(1'b1, MQS_REG_CTRL, 32'h0000011A);
    for (int p = 0; p < 3; p++) begin
      for (int n = 0; n <= 200; n++) begin
        @(posedge clk);
        #1;
        if (sync === 1'b1) break;
        if (n == 200) hang();
      end
    end
    for (int k = 1; k <= 4; k++) begin
      @(posedge clk);
      #1 chk("sync", sync, k == 4);
      chk("token", tok_out, k == 3);
    end
    chk("oe polled", oe, 1'b1);
  endtask

  // Non-master with its own loop never receives a token
  task automatic sc_slave();
    @(posedge clk);
    master_select <= 1'b0;
    do_reset(1'b1);
    at(20);
    #1 chk("oe slave", oe, 1'b0);
    chk("sync slave", sync, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    req = '0;
    rst_b = 1'b0;
    {raen, ren, waen, wen, full_status_strobe, fm} = 6'h00;
    rqa = 7'h00;
    wqa = 8'h00;
    master_select = 1'b1;
    did = 3'h0;
    err_count = 0;
    num_checks = 0;
    do_reset(1'b0);
    sc_regs();
    sc_empty_flag();
    sc_words();
    sc_offsets();
    sc_polled();
    sc_slave();
    final_report();
  end
endmodule
